// >>> src/ads_status_top.sv
/*
  Per-axis drive status logic for a four-axis pulse-train controller:
  compare flags, speed and jerk phase, sticky drive end causes, limit
  lockout, stop requests, main error flags and one interrupt.
  Assumes a pulse generator on the same clock supplies drive state and
  acts on the start and stop requests; stop pins are asynchronous.
*/
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "ads_defines.svh"

// How it works
// - Four status copies; host read returns the currently selected axis.
// - Bit 0 high while selected position count is at or above upper compare.
// - Bit 1 high while selected position count is below lower compare.
// - Bits 2..4 show accelerating, constant and decelerating, one at a time.
// - Fixed drive ending by pulse count sets no end-cause flag.
// - Host decel or immediate stop command ends the drive accordingly.
// - Enabled soft limit ends drive; cause kept in error status register.
// - Enabled external decel input active during drive stops it, sets bits 11..8.
// - Limit input active stops drive, sets bit 12 or 13.
// - Enabled servo fault input active stops drive, sets bit 14.
// - Emergency input low stops drive, sets bit 15.
// - Bits 8..15 stay set after input returns, until cleared.
// - Any of bits 12..15 set raises that axis's main error flag.
// - Next accepted drive command clears that axis's end-cause flags.
// - Command 25h clears the end-cause flags.
// - After limit stop on the travel side, new drive in that same direction is refused.
// - Soft limit: compare value passed in matching direction, when enabled.
module ads_status_top
  import ads_pkg::*;
(
  input wire logic i_clk, // System clock, 25 MHz
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic i_ce, // Clock enable, freezes all state when low
  input wire logic [`ADS_AW-1:0] i_addr, // Register index
  input wire logic [`ADS_DW-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [`ADS_DW-1:0] o_rdata, // Read data, cycle after strobe
  input wire ads_drv_t [`ADS_AXES-1:0] i_drv, // Generator state per axis
  output ads_cmd_t [`ADS_AXES-1:0] o_cmd, // Requests to generator
  input wire ads_pin_t [`ADS_AXES-1:0] i_pin, // Stop pins per axis
  input wire logic i_emergency_halt_input_n, // Emergency stop pin, low active
  output logic [`ADS_AXES-1:0] o_axis_err, // Main status error flag per axis
  output logic o_irq // Interrupt, high active level
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int PW = $bits(ads_pin_t);
  localparam int SW = `ADS_AXES * PW + 1;

  logic [SW-1:0] pins_s;
  ads_pin_t [`ADS_AXES-1:0] pin_s;
  logic emg_s;

  // All pins idle high; one bundle keeps the design flat
  ads_sync #(
    .W(SW)
  ) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_async({i_emergency_halt_input_n, i_pin}),
    .i_rst_val({SW{1'b1}}),
    .o_sync(pins_s)
  );

  assign pin_s = pins_s[SW-2:0];
  assign emg_s = ~pins_s[SW-1];

  // ----------------------------------------
  // Common registers
  // ----------------------------------------
  logic [1:0] axsel_q;
  logic [2*`ADS_AXES-1:0] int_stat_q;
  logic [2*`ADS_AXES-1:0] int_en_q;
  logic [2*`ADS_AXES-1:0] int_ev;
  logic wr_axsel;
  logic wr_cmd;
  logic [7:0] cmd_code;

  assign wr_axsel = i_wr && (i_addr == `ADS_OFS_AXSEL);
  assign wr_cmd = i_wr && (i_addr == `ADS_OFS_CMD);
  assign cmd_code = i_wdata[7:0];

  // Axis selection for reads and per-axis writes
  // selected axis
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      axsel_q <= 2'h0;
    end else if (i_ce && wr_axsel) begin
      axsel_q <= i_wdata[1:0];
    end
  end

  // Per-axis views for the read mux
  logic [`ADS_DW-1:0] stat1_v [`ADS_AXES];
  logic [`ADS_DW-1:0] err_v [`ADS_AXES];
  logic [`ADS_CFG_W-1:0] cfg_v [`ADS_AXES];
  logic [`ADS_PW-1:0] cmpu_v [`ADS_AXES];
  logic [`ADS_PW-1:0] cmpl_v [`ADS_AXES];
  logic [`ADS_AXES-1:0] err_any;
  logic [`ADS_AXES-1:0] busy_v;

  // ----------------------------------------
  // Per-axis logic
  // ----------------------------------------
  for (genvar a = 0; a < `ADS_AXES; a++) begin : g_ax
    logic [`ADS_CFG_W-1:0] cfg_q;
    logic [`ADS_PW-1:0] cmpu_q;
    logic [`ADS_PW-1:0] cmpl_q;
    logic [7:0] end_q;
    logic [1:0] soft_q;
    logic [1:0] lock_q;
    logic busy_q;
    ads_cmd_t cmd_q;
    logic sel;
    logic hit;
    logic busy;
    logic dneg;
    logic signed [`ADS_PW-1:0] pos;
    logic ge_up;
    logic lt_lo;
    logic [3:0] ext_hit;
    logic limp_hit;
    logic limn_hit;
    logic alm_hit;
    logic emg_hit;
    logic softp_hit;
    logic softn_hit;
    logic lim_any;
    logic is_start;
    logic start_neg;
    logic start_ok;
    logic clr;
    logic [7:0] end_set;
    logic [2:0] spd;
    logic [2:0] jrk;

    assign sel = (axsel_q == 2'(a));
    assign hit = wr_cmd && i_wdata[`ADS_CMD_MASK_LO + a];
    assign busy = i_drv[a].busy;
    assign dneg = i_drv[a].dir_neg;

    // Position source chosen by configuration
    assign pos = cfg_q[`ADS_CFG_SRC_ACT] ? i_drv[a].act_pos : i_drv[a].log_pos;
    assign ge_up = pos >= $signed(cmpu_q);
    assign lt_lo = pos < $signed(cmpl_q);

    // Stop causes, only while a drive runs
    // external decel inputs
    assign ext_hit = {4{busy}} & ~pin_s[a].ext_decel_stop_inputs_n
                     & cfg_q[`ADS_CFG_EXT_LO +: 4];
    assign limp_hit = busy && !pin_s[a].pos_limit_input_n;
    assign limn_hit = busy && !pin_s[a].neg_limit_input_n;
    assign alm_hit = busy && cfg_q[`ADS_CFG_ALM_EN] && !pin_s[a].servo_fault_input_n;
    assign emg_hit = busy && emg_s;
    // soft limit passed in travel direction
    assign softp_hit = busy && !dneg && cfg_q[`ADS_CFG_SLIM_EN] && (pos > $signed(cmpu_q));
    assign softn_hit = busy && dneg && cfg_q[`ADS_CFG_SLIM_EN] && (pos < $signed(cmpl_q));
    assign lim_any = limp_hit || limn_hit || softp_hit || softn_hit;

    // Drive command decode and acceptance
    assign is_start = hit && (cmd_code inside {`ADS_CMD_FIX_POS, `ADS_CMD_FIX_NEG,
                                               `ADS_CMD_CONT_POS, `ADS_CMD_CONT_NEG});
    assign start_neg = cmd_code[0];
    assign start_ok = is_start && !busy && !lock_q[start_neg];
    // clear on next drive or 25h
    assign clr = start_ok || (hit && (cmd_code == `ADS_CMD_END_CLR));
    assign end_set = {emg_hit, alm_hit, limn_hit, limp_hit, ext_hit};

    // Configuration and compare values of the selected axis
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        cfg_q <= `ADS_CFG_RST;
        cmpu_q <= `ADS_CMP_RST;
        cmpl_q <= `ADS_CMP_RST;
      end else if (i_ce && i_wr && sel) begin
        unique case (i_addr)
          `ADS_OFS_CFG: cfg_q <= i_wdata[`ADS_CFG_W-1:0];
          `ADS_OFS_CMPU_L: cmpu_q[15:0] <= i_wdata;
          `ADS_OFS_CMPU_H: cmpu_q[31:16] <= i_wdata;
          `ADS_OFS_CMPL_L: cmpl_q[15:0] <= i_wdata;
          `ADS_OFS_CMPL_H: cmpl_q[31:16] <= i_wdata;
          default: ;
        endcase
      end
    end

    // Sticky end causes; a new cause wins over a clear
    // sticky flags
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        end_q <= 8'h00;
        soft_q <= 2'h0;
      end else if (i_ce) begin
        end_q <= (end_q & ~{8{clr}}) | end_set;
        soft_q <= (soft_q & ~{2{clr}}) | {softn_hit, softp_hit};
      end
    end

    // Direction lockout after a limit stop
    // lock travel direction
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        lock_q <= 2'h0;
      end else if (i_ce) begin
        lock_q[0] <= (lock_q[0] && !(start_ok && start_neg)) || softp_hit || (limp_hit && !dneg);
        lock_q[1] <= (lock_q[1] && !(start_ok && !start_neg)) || softn_hit || (limn_hit && dneg);
      end
    end

    // Requests to the pulse generator
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        cmd_q <= '0;
      end else if (i_ce) begin
        cmd_q.start <= start_ok;
        if (start_ok) begin
          cmd_q.dir_neg <= start_neg;
          cmd_q.fixed <= !cmd_code[1];
        end
        cmd_q.stop_decel <= (hit && (cmd_code == `ADS_CMD_DECEL_STOP)) || (|ext_hit)
                            || (lim_any && cfg_q[`ADS_CFG_LIM_DECEL]);
        cmd_q.stop_now <= (hit && (cmd_code == `ADS_CMD_NOW_STOP)) || alm_hit || emg_hit
                          || (lim_any && !cfg_q[`ADS_CFG_LIM_DECEL]);
      end
    end

    // Busy history for the drive end event
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        busy_q <= 1'b0;
      end else if (i_ce) begin
        busy_q <= busy;
      end
    end

    // Speed phase, one bit at a time
    // accel, constant, decel
    always_comb begin
      spd = 3'h0;
      if (busy) begin
        unique case (i_drv[a].speed)
          ADS_SP_ACC: spd = 3'h1;
          ADS_SP_CONST: spd = 3'h2;
          ADS_SP_DEC: spd = 3'h4;
          ADS_SP_IDLE: spd = 3'h0;
        endcase
      end
    end

    // Jerk phase in S-curve drives
    // jerk rising, flat, falling
    always_comb begin
      jrk = 3'h0;
      if (busy && i_drv[a].scurve) begin
        unique case (i_drv[a].jerk)
          ADS_JK_RISE: jrk = 3'h1;
          ADS_JK_FLAT: jrk = 3'h2;
          ADS_JK_FALL: jrk = 3'h4;
          ADS_JK_NONE: jrk = 3'h0;
        endcase
      end
    end

    // Views for reads, main status and interrupts
    assign stat1_v[a] = {end_q, jrk, spd, lt_lo, ge_up};
    assign err_v[a] = {10'h000, emg_s, !pin_s[a].servo_fault_input_n && cfg_q[`ADS_CFG_ALM_EN],
                       !pin_s[a].neg_limit_input_n, !pin_s[a].pos_limit_input_n, soft_q};
    assign cfg_v[a] = cfg_q;
    assign cmpu_v[a] = cmpu_q;
    assign cmpl_v[a] = cmpl_q;
    assign err_any[a] = (|end_q[7:4]) || (|soft_q);
    assign busy_v[a] = busy;
    assign int_ev[a] = busy_q && !busy;
    assign int_ev[`ADS_AXES + a] = (|end_set[7:4]) || softp_hit || softn_hit;
    assign o_cmd[a] = cmd_q;
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // Sticky status; an event wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      int_stat_q <= 8'h00;
    end else if (i_ce) begin
      int_stat_q <= (int_stat_q & ~((i_wr && (i_addr == `ADS_OFS_INT_CLR)) ? i_wdata[7:0] : 8'h00))
                    | int_ev;
    end
  end

  // Enable mask
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      int_en_q <= 8'h00;
    end else if (i_ce && i_wr && (i_addr == `ADS_OFS_INT_EN)) begin
      int_en_q <= i_wdata[7:0];
    end
  end

  // Level output, one cycle behind the status
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(int_stat_q & int_en_q);
    end
  end

  // ----------------------------------------
  // Main status and read port
  // ----------------------------------------
  // Error flags per axis
  // main error output
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_axis_err <= 4'h0;
    end else if (i_ce) begin
      o_axis_err <= err_any;
    end
  end

  // Read data for exactly one cycle after the strobe
  // axis chosen by selection
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= `ADS_RD_RST;
    end else if (i_ce) begin
      o_rdata <= `ADS_RD_RST;
      if (i_rd) begin
        unique case (i_addr)
          `ADS_OFS_AXSEL: o_rdata <= {14'h0000, axsel_q};
          `ADS_OFS_STAT1: o_rdata <= stat1_v[axsel_q];
          `ADS_OFS_ERR: o_rdata <= err_v[axsel_q];
          `ADS_OFS_MAIN: o_rdata <= {8'h00, busy_v, err_any};
          `ADS_OFS_CFG: o_rdata <= {8'h00, cfg_v[axsel_q]};
          `ADS_OFS_CMPU_L: o_rdata <= cmpu_v[axsel_q][15:0];
          `ADS_OFS_CMPU_H: o_rdata <= cmpu_v[axsel_q][31:16];
          `ADS_OFS_CMPL_L: o_rdata <= cmpl_v[axsel_q][15:0];
          `ADS_OFS_CMPL_H: o_rdata <= cmpl_v[axsel_q][31:16];
          `ADS_OFS_INT_STAT: o_rdata <= {8'h00, int_stat_q};
          `ADS_OFS_INT_EN: o_rdata <= {8'h00, int_en_q};
          default: o_rdata <= `ADS_RD_RST;
        endcase
      end
    end
  end
endmodule

// >>> src/ads_defines.svh
/*
  Constants of the per-axis drive status block: register offsets,
  field positions, command codes and reset values.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef ADS_DEFINES_SVH
`define ADS_DEFINES_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define ADS_AXES 4
`define ADS_AW 4
`define ADS_DW 16
`define ADS_PW 32

// ----------------------------------------
// Register offsets (word index)
// ----------------------------------------
`define ADS_OFS_AXSEL 4'h0
`define ADS_OFS_CMD 4'h1
`define ADS_OFS_STAT1 4'h2
`define ADS_OFS_ERR 4'h3
`define ADS_OFS_MAIN 4'h4
`define ADS_OFS_CFG 4'h5
`define ADS_OFS_CMPU_L 4'h6
`define ADS_OFS_CMPU_H 4'h7
`define ADS_OFS_CMPL_L 4'h8
`define ADS_OFS_CMPL_H 4'h9
`define ADS_OFS_INT_STAT 4'hA
`define ADS_OFS_INT_CLR 4'hB
`define ADS_OFS_INT_EN 4'hC

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define ADS_CFG_SRC_ACT 0
`define ADS_CFG_SLIM_EN 1
`define ADS_CFG_ALM_EN 2
`define ADS_CFG_LIM_DECEL 3
`define ADS_CFG_EXT_LO 4
`define ADS_CFG_W 8
`define ADS_CFG_RST 8'h00

// ----------------------------------------
// Command register fields and codes
// ----------------------------------------
`define ADS_CMD_MASK_LO 8
`define ADS_CMD_FIX_POS 8'h20
`define ADS_CMD_FIX_NEG 8'h21
`define ADS_CMD_CONT_POS 8'h22
`define ADS_CMD_CONT_NEG 8'h23
`define ADS_CMD_END_CLR 8'h25
`define ADS_CMD_DECEL_STOP 8'h26
`define ADS_CMD_NOW_STOP 8'h27

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADS_CMP_RST 32'h0000_0000
`define ADS_RD_RST 16'h0000

`endif

// >>> src/ads_pkg.sv
/*
  Types of the per-axis drive status block.
  Assumes the defines header is on the include path.
*/
`include "ads_defines.svh"

package ads_pkg;
  // Speed phase reported by the pulse generator
  typedef enum logic [1:0] {ADS_SP_IDLE = 2'h0, ADS_SP_ACC = 2'h1, ADS_SP_CONST = 2'h2,
                            ADS_SP_DEC = 2'h3} ads_speed_t;
  // Jerk phase reported during S-curve drives
  typedef enum logic [1:0] {ADS_JK_NONE = 2'h0, ADS_JK_RISE = 2'h1, ADS_JK_FLAT = 2'h2,
                            ADS_JK_FALL = 2'h3} ads_jerk_t;
  // Per-axis state from the pulse generator (same clock)
  typedef struct packed {
    logic busy;
    logic dir_neg;
    logic scurve;
    ads_speed_t speed;
    ads_jerk_t jerk;
    logic [`ADS_PW-1:0] log_pos;
    logic [`ADS_PW-1:0] act_pos;
  } ads_drv_t;
  // Per-axis request to the pulse generator
  typedef struct packed {
    logic start;
    logic dir_neg;
    logic fixed;
    logic stop_decel;
    logic stop_now;
  } ads_cmd_t;
  // Per-axis pins, all active low
  typedef struct packed {
    logic [3:0] ext_decel_stop_inputs_n;
    logic pos_limit_input_n;
    logic neg_limit_input_n;
    logic servo_fault_input_n;
  } ads_pin_t;
endpackage

// >>> src/ads_sync.sv
/*
  Two-flop synchroniser for a bundle of asynchronous levels.
  Assumes the inputs are levels; pulses shorter than a clock may be lost.
*/
`timescale 1ns/100ps

module ads_sync #(
  parameter int W = 1
) (
  input wire logic i_clk, // System clock
  input wire logic i_resetn, // Synchronous reset, active low
  input wire logic i_ce, // Clock enable
  input wire logic [W-1:0] i_async, // Asynchronous levels
  input wire logic [W-1:0] i_rst_val, // Idle level after reset (constant)
  output logic [W-1:0] o_sync // Synchronised levels
);
  logic [W-1:0] meta_q;

  // Two stages, the first read only by the second
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_q <= i_rst_val;
      o_sync <= i_rst_val;
    end else if (i_ce) begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// >>> bench/ads_status_chk.sv
/*
  Port checks of the drive status block.
  Assumes one clock and i_ce held high.
*/
`timescale 1ns/100ps
`include "ads_defines.svh"
module ads_status_chk
  import ads_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_resetn, // Reset, low
  input wire logic i_ce, // Enable
  input wire logic [`ADS_AW-1:0] i_addr, // Index
  input wire logic [`ADS_DW-1:0] i_wdata, // Write data
  input wire logic i_wr, // Write
  input wire logic i_rd, // Read
  input wire logic [`ADS_DW-1:0] o_rdata, // Read data
  input wire ads_drv_t [`ADS_AXES-1:0] i_drv, // Drive state
  input wire ads_cmd_t [`ADS_AXES-1:0] o_cmd, // Requests
  input wire ads_pin_t [`ADS_AXES-1:0] i_pin, // Stop pins
  input wire logic i_emergency_halt_input_n, // Emergency
  input wire logic [`ADS_AXES-1:0] o_axis_err, // Error flags
  input wire logic o_irq // Interrupt
);
  // ----
  // Helpers
  // ----
  logic cmd_wr;
  logic [3:0] start_v;
  assign cmd_wr = i_wr && i_addr == `ADS_OFS_CMD;
  // Start pulses of all axes
  always_comb begin
    for (int a = 0; a < `ADS_AXES; a++) start_v[a] = o_cmd[a].start;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // ----
  // Properties
  // ----
  // Quiet outside read slot
  property p_rd_quiet;
    !$past(i_rd) |-> o_rdata == '0;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
  property p_start_src;
    |start_v |-> $past(cmd_wr) && $past(i_wdata[7:2]) == 6'h08 && ($past(i_wdata[11:8]) & start_v) == start_v;
  endproperty
  a_start_src: assert property (p_start_src) else $error("start without drive command");
  property p_start_once;
    o_cmd[0].start |=> !o_cmd[0].start;
  endproperty
  a_start_once: assert property (p_start_once) else $error("start longer than one cycle");
  property p_start_dir;
    o_cmd[0].start |-> o_cmd[0].dir_neg == $past(i_wdata[0]) && $past(i_wdata[8]);
  endproperty
  a_start_dir: assert property (p_start_dir) else $error("start direction wrong");
  property p_busy_refuse;
    cmd_wr && i_drv[0].busy |=> !o_cmd[0].start;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("start while busy");
  property p_host_stop;
    cmd_wr && i_wdata[8] && i_wdata[7:0] == 8'h27 && i_drv[0].busy |=> o_cmd[0].stop_now;
  endproperty
  a_host_stop: assert property (p_host_stop) else $error("immediate stop not issued");
  property p_emg_stop;
    (!i_emergency_halt_input_n && i_drv[0].busy) [*3] |-> ##[0:2] o_cmd[0].stop_now;
  endproperty
  a_emg_stop: assert property (p_emg_stop) else $error("emergency did not stop");
  property p_lim_stop;
    (!i_pin[0].pos_limit_input_n && i_drv[0].busy) [*3] |-> ##[0:2] (o_cmd[0].stop_now || o_cmd[0].stop_decel);
  endproperty
  a_lim_stop: assert property (p_lim_stop) else $error("limit did not stop");
  property p_err_hold;
    o_axis_err[0] && !cmd_wr && !$past(cmd_wr) |=> o_axis_err[0];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
  // Main scenarios reached
  c_start: cover property (|start_v);
  c_stop: cover property (o_cmd[0].stop_now);
  c_irq: cover property ($rose(o_irq));
endmodule

bind ads_status_top ads_status_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_drv(i_drv), .o_cmd(o_cmd), .i_pin(i_pin),
  .i_emergency_halt_input_n(i_emergency_halt_input_n), .o_axis_err(o_axis_err), .o_irq(o_irq));

// >>> bench/ads_gen_model.sv
/*
  Pulse generator stand-in: drive phases per axis.
  Assumes the block's clock; position comes from the bench.
*/
`timescale 1ns/100ps
`include "ads_defines.svh"
module ads_gen_model
  import ads_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_resetn, // Reset, low
  input wire ads_cmd_t [`ADS_AXES-1:0] i_cmd, // Requests
  input wire logic [`ADS_PW-1:0] i_pos, // Position
  input wire logic i_scurve, // S-curve drives
  output ads_drv_t [`ADS_AXES-1:0] o_drv // Drive state
);
  logic [3:0] busy_q, dir_q, sc_q, fix_q;
  logic [3:0] cnt_q [4];
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      busy_q <= '0;
      dir_q <= '0;
      sc_q <= '0;
      fix_q <= '0;
      cnt_q <= '{default: 4'h0};
    end else begin
      for (int a = 0; a < 4; a++) begin
        if (i_cmd[a].stop_now) begin
          busy_q[a] <= 1'b0;
        end else if (i_cmd[a].start) begin
          busy_q[a] <= 1'b1;
          dir_q[a] <= i_cmd[a].dir_neg;
          sc_q[a] <= i_scurve;
          fix_q[a] <= i_cmd[a].fixed;
          cnt_q[a] <= 4'h0;
        end else if (busy_q[a]) begin
          if (i_cmd[a].stop_decel && cnt_q[a] < 4'hC) cnt_q[a] <= 4'hC;
          else if (cnt_q[a] == 4'hF) busy_q[a] <= 1'b0;
          else if (fix_q[a] || cnt_q[a] != 4'hB) cnt_q[a] <= cnt_q[a] + 4'h1;
        end
      end
    end
  end
  // Phases: 0-3 accel, 4-11 constant, 12-15 decel
  always_comb begin
    for (int a = 0; a < 4; a++) begin
      o_drv[a].busy = busy_q[a];
      o_drv[a].dir_neg = dir_q[a];
      o_drv[a].scurve = sc_q[a];
      o_drv[a].speed = !busy_q[a] ? ADS_SP_IDLE : cnt_q[a] < 4'h4 ? ADS_SP_ACC :
                       cnt_q[a] < 4'hC ? ADS_SP_CONST : ADS_SP_DEC;
      o_drv[a].jerk = !(busy_q[a] && sc_q[a]) || (cnt_q[a] > 4'h3 && cnt_q[a] < 4'hC) ? ADS_JK_NONE :
                      cnt_q[a][1] ? (cnt_q[a][0] ? ADS_JK_FALL : ADS_JK_FLAT) : ADS_JK_RISE;
      o_drv[a].log_pos = i_pos;
      o_drv[a].act_pos = -i_pos;
    end
  end
endmodule

// >>> bench/testbench.sv
/*
  Self-checking bench of the drive status block.
  Assumes the generator model answers the request port.
*/
`timescale 1ns/100ps
`include "ads_defines.svh"
module testbench
  import ads_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, emg_n = 1'b1, irq;
  logic [3:0] addr = '0, err, act_a;
  logic [15:0] wdata = '0, rdata, d;
  logic [31:0] pos = '0;
  logic [31:0] up_a [4], lo_a [4];
  ads_drv_t [3:0] drv, snap;
  ads_cmd_t [3:0] cmd;
  ads_pin_t [3:0] pin = '1;
  int bad_count = 0, checks_done = 0, cyc = 0, n;
  ads_status_top DUT (.i_clk(clk), .i_resetn(resetn), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_drv(drv), .o_cmd(cmd), .i_pin(pin), .i_emergency_halt_input_n(emg_n),
    .o_axis_err(err), .o_irq(irq));
  ads_gen_model u_gen (.i_clk(clk), .i_resetn(resetn), .i_cmd(cmd), .i_pos(pos), .i_scurve(1'b1), .o_drv(drv));
  // ----
  // Tasks
  // ----
  always #20 clk = ~clk;
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read; snap keeps drive state of the read edge
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(negedge clk);
    snap = drv;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    q = rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_cmp(input logic [63:0] v);
    for (int j = 0; j < 4; j++) bus_wr(4'(`ADS_OFS_CMPU_L + j), v[16*j +: 16]);
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Low byte of the status word from drive state
  function automatic logic [15:0] exp_lo(input ads_drv_t s, input logic [31:0] up, input logic [31:0] lo,
                                         input logic act);
    logic signed [31:0] p;
    p = act ? s.act_pos : s.log_pos;
    exp_lo = '0;
    exp_lo[0] = p >= $signed(up);
    exp_lo[1] = p < $signed(lo);
    exp_lo[4:2] = s.busy ? {s.speed == ADS_SP_DEC, s.speed == ADS_SP_CONST, s.speed == ADS_SP_ACC} : 3'h0;
    exp_lo[7:5] = s.busy && s.scurve ? {s.jerk == ADS_JK_FALL, s.jerk == ADS_JK_FLAT, s.jerk == ADS_JK_RISE} : 3'h0;
  endfunction
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      $display("unexpected at %0t: run too long", $time);
      summarize();
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    void'($urandom(82769));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    // Compare flags per axis, extremes first
    for (int k = 0; k < 10; k++) begin
      n = k % 4;
      up_a[n] = k == 0 ? 32'h8000_0000 : k == 1 ? 32'h7FFF_FFFF : $urandom;
      lo_a[n] = k < 2 ? up_a[n] : $urandom;
      act_a[n] = k[2];
      @(posedge clk);
      pos <= k < 2 ? up_a[n] : $urandom;
      bus_wr(`ADS_OFS_AXSEL, 16'(n));
      bus_wr(`ADS_OFS_CFG, {15'h0, act_a[n]});
      wr_cmp({lo_a[n], up_a[n]});
      bus_rd(`ADS_OFS_STAT1, d);
      chk(d, exp_lo(snap[n], up_a[n], lo_a[n], act_a[n]));
    end
    for (int k = 0; k < 4; k++) begin
      bus_wr(`ADS_OFS_AXSEL, 16'(k));
      bus_rd(`ADS_OFS_CMPL_H, d);
      chk(d, lo_a[k][31:16]);
    end
    bus_rd(`ADS_OFS_CMD, d);
    chk(d, 16'h0000);
    bus_rd(4'hD, d);
    chk(d, 16'h0000);
    $display("test done: compare");
    // Fixed drive on axis 1, phases and end interrupt
    bus_wr(`ADS_OFS_INT_EN, 16'h00FF);
    bus_wr(`ADS_OFS_AXSEL, 16'h0001);
    bus_wr(`ADS_OFS_CMD, 16'h0220);
    for (int k = 0; k < 30 && (k < 2 || snap[1].busy); k++) begin
      bus_rd(`ADS_OFS_STAT1, d);
      chk(d, exp_lo(snap[1], up_a[1], lo_a[1], act_a[1]));
    end
    repeat (2) @(negedge clk);
    chk(16'(irq), 16'h0001);
    bus_rd(`ADS_OFS_INT_STAT, d);
    chk(d, 16'h0002);
    bus_wr(`ADS_OFS_INT_CLR, 16'h0002);
    bus_rd(`ADS_OFS_INT_STAT, d);
    chk({d[15:1], irq}, 16'h0000);
    $display("test done: phases");
    // Host decel and immediate stops, interrupt masked
    bus_wr(`ADS_OFS_INT_EN, 16'h0000);
    bus_wr(`ADS_OFS_AXSEL, 16'h0000);
    bus_wr(`ADS_OFS_CFG, 16'h00F4);
    for (int k = 0; k < 2; k++) begin
      bus_wr(`ADS_OFS_CMD, 16'h0122);
      repeat (20) @(posedge clk);
      bus_wr(`ADS_OFS_CMD, 16'h0126 + 16'(k));
      #1;
      for (n = 0; n < 20 && drv[0].busy; n++) #40;
      chk(16'(n > 2), 16'(k == 0));
      bus_rd(`ADS_OFS_STAT1, d);
      chk(d & 16'hFF00, 16'h0000);
      bus_rd(`ADS_OFS_INT_STAT, d);
      chk({d[3:0], 3'h0, irq}, 16'h0010);
      bus_wr(`ADS_OFS_INT_CLR, 16'h00FF);
    end
    $display("test done: host stops");
    // Each stop input, sticky flags, both clears
    for (int c = 0; c < 8; c++) begin
      bus_wr(`ADS_OFS_CMD, c == 4 ? 16'h0123 : 16'h0122);
      bus_rd(`ADS_OFS_STAT1, d);
      chk(d & 16'hFF00, 16'h0000);
      @(posedge clk);
      pin[0] <= ads_pin_t'(c < 7 ? ~(7'h01 << (c < 4 ? 3 + c : 6 - c)) : 7'h7F);
      emg_n <= c != 7;
      repeat (8) @(posedge clk);
      pin[0] <= '1;
      emg_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk(16'(drv[0].busy), 16'h0000);
      bus_rd(`ADS_OFS_STAT1, d);
      chk(d & 16'hFF00, 16'h0100 << c);
      chk(16'(err[0]), 16'(c > 3));
      if (!c[0]) begin
        bus_wr(`ADS_OFS_CMD, 16'h0125);
        bus_rd(`ADS_OFS_STAT1, d);
        chk(d & 16'hFF00, 16'h0000);
      end
    end
    $display("test done: stop inputs");
    // Limit lockout in travel direction
    bus_wr(`ADS_OFS_CMD, 16'h0122);
    @(posedge clk);
    pin[0] <= ads_pin_t'(7'h7B);
    repeat (8) @(posedge clk);
    pin[0] <= '1;
    bus_wr(`ADS_OFS_CMD, 16'h0125);
    for (int k = 0; k < 3; k++) begin
      bus_wr(`ADS_OFS_CMD, 16'h0122 + 16'(k));
      repeat (3) @(posedge clk);
      chk(16'(drv[0].busy), 16'(k > 0));
    end
    bus_wr(`ADS_OFS_CMD, 16'h0127);
    $display("test done: lockout");
    // Soft limit: equal keeps running, one past stops
    bus_wr(`ADS_OFS_CFG, 16'h00F6);
    wr_cmp({32'hFFFF_FF9C, 32'h0000_0064});
    pos <= 32'h0000_0064;
    bus_wr(`ADS_OFS_CMD, 16'h0122);
    repeat (6) @(posedge clk);
    chk(16'(drv[0].busy), 16'h0001);
    pos <= 32'h0000_0065;
    repeat (6) @(posedge clk);
    chk(16'(drv[0].busy), 16'h0000);
    bus_rd(`ADS_OFS_STAT1, d);
    chk(d, 16'h0001);
    bus_rd(`ADS_OFS_ERR, d);
    chk(d & 16'h0001, 16'h0001);
    $display("test done: soft limit");
    summarize();
  end
endmodule
